// [rtl/curtain_regs.svh]
// Summary of operation
// (R01) auto start: outputs on whenever beams clear
// (R02) manual start: press 50..5000 ms, on at release
// (R03) manual with off: same press also switches off
// (R04) start release rising edge energizes when clear
// (R05) reject start release with contactor monitoring
// (R06) feedback must toggle in time, else lockout
// (R07) monitor time 50..1275 ms, 5 ms, default 300
// (R08) range select long or short, default long
// (R09) beam coding changes scan, longer response
// (R10) interference rejection alters coded scan pattern
// (R11) test input switches outputs per configuration
// (R12) double scan: off after two interrupted scans
// (R13) multiple scan: three scans, response plus third
// (R14) short interruption filter 0..174 ms, 2 ms
// (R15) threshold: over two clears in off, hold off; code applies it in auto start only
// (R16) on/off times 30..5000 ms, on not below off
// (R17) same settings serve muting and blanking
// (R18) qualified interruption always drops the outputs
`ifndef CURTAIN_REGS_SVH
`define CURTAIN_REGS_SVH
// register byte offsets
`define OFS_CTRL 5'h00
`define OFS_MON_TIME 5'h04
`define OFS_FILTER 5'h08
`define OFS_THRESH 5'h0C
`define OFS_STATUS 5'h10
`define OFS_IRQ_STATUS 5'h14
`define OFS_IRQ_MASK 5'h18
`define OFS_RESP_TIME 5'h1C
// control field positions
`define CTRL_MODE_LSB 0
`define CTRL_REL_EN 2
`define CTRL_MON_EN 3
`define CTRL_SHORT_RANGE 4
`define CTRL_CODING 5
`define CTRL_REJECT 6
`define CTRL_TEST_EN 7
`define CTRL_TEST_ON_HIGH 8
`define CTRL_MULTI_SCAN 9
`define CTRL_THRESH_EN 10
`define CTRL_MUTING_EN 11
`define CTRL_BLANKING_EN 12
`define CTRL_W 13
// reset values
`define CTRL_RESET 13'h0000
`define MON_STEPS_RESET 8'h3C
`define FILTER_RESET 7'h00
`define ON_MS_RESET 13'h01F4
`define OFF_MS_RESET 13'h00FA
// timing, times in ms unless stated
`define CLK_PERIOD_PS 5000
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES ((`TICK_PERIOD_NS * 1000) / `CLK_PERIOD_PS)
`define PRESS_MIN_MS 13'd50
`define PRESS_MAX_MS 13'd5000
`define MON_STEP_MS 11'd5
`define MON_STEPS_MIN 8'd10
`define FILTER_STEPS_MAX 7'd87
`define THRESH_MIN_MS 13'd30
`define THRESH_MAX_MS 13'd5000
`endif

// [rtl/curtain_pkg.sv]
`include "curtain_regs.svh"
package curtain_pkg;
  // output control states, gray along off, armed, on, hold
  typedef enum logic [2:0] {
    S_OFF = 3'h0,
    S_ARMED = 3'h1,
    S_ON = 3'h3,
    S_HOLD = 3'h2,
    S_LOCK = 3'h6
  } state_t;
  // start mode field encodings
  typedef enum logic [1:0] {
    M_AUTO = 2'h0,
    M_MANUAL = 2'h1,
    M_MANUAL_OFF = 2'h2
  } start_mode_t;
endpackage

// [rtl/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable every CYCLES clocks
module tick_divider #(
  parameter int CYCLES = 200000
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  if (CYCLES < 2) begin : g_bad
    $error("tick divider needs at least two cycles");
  end
  logic [31:0] count; // cycles since last tick
  // free running count, pulse on wrap
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count == 32'(CYCLES - 1)) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser with edge pulses taken from the second stage
module pin_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta; // first stage, read only by the second
  logic prev; // level one cycle back
  // the chain resets low, so a pin already high at reset release gives one rise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end
  assign rise = level & ~prev;
  assign fall = prev & ~level;
endmodule
`default_nettype wire

// [rtl/protective_output_start_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "curtain_regs.svh"
module protective_output_start_control #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int BASE_RESP_MS = 10,
  parameter int CODING_ADD_MS = 4,
  parameter int REJECT_ADD_MS = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire logic scan_strobe,
  input wire logic scan_interrupted,
  input wire logic start_button,
  input wire logic start_release,
  input wire logic contactor_feedback,
  input wire logic test_pin,
  output logic [1:0] protective_switch_output,
  output logic [1:0] scan_pattern,
  output logic short_range,
  output logic waiting_for_start,
  output logic lockout,
  output logic irq
);
  import curtain_pkg::*;
  if (BASE_RESP_MS < 1 || CODING_ADD_MS < 0 || REJECT_ADD_MS < 0 ||
      BASE_RESP_MS + CODING_ADD_MS + REJECT_ADD_MS > 4000) begin : g_bad
    $error("response time figures out of range");
  end

  logic tick; // one ms enable
  tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .resetn(resetn),
    .tick(tick)
  );

  // pin inputs pass two flops before use
  logic start_lvl, start_fall, rel_rise, fb_rise, fb_fall, test_lvl;
  pin_sync u_start (
    .clk(clk), .resetn(resetn), .pin(start_button),
    .level(start_lvl), .rise(), .fall(start_fall)
  );
  pin_sync u_rel (
    .clk(clk), .resetn(resetn), .pin(start_release),
    .level(), .rise(rel_rise), .fall()
  );
  pin_sync u_fb (
    .clk(clk), .resetn(resetn), .pin(contactor_feedback),
    .level(), .rise(fb_rise), .fall(fb_fall)
  );
  pin_sync u_test (
    .clk(clk), .resetn(resetn), .pin(test_pin),
    .level(test_lvl), .rise(), .fall()
  );

  // configuration
  logic [`CTRL_W-1:0] ctrl; // general settings
  logic [7:0] mon_steps; // monitor time in 5 ms steps
  logic [6:0] filter_steps; // short interruption filter, 2 ms steps
  logic [12:0] on_ms; // threshold hold time
  logic [12:0] off_ms; // threshold observation window
  logic [3:0] irq_status; // sticky events
  logic [3:0] irq_mask; // enables onto irq
  state_t state;
  state_t next_state;

  // settings decode; one copy serves muting and blanking alike
  start_mode_t mode;
  logic rel_en, mon_en, multi, thr_en;
  assign mode = start_mode_t'(ctrl[`CTRL_MODE_LSB +: 2]); // see (R17)
  assign rel_en = ctrl[`CTRL_REL_EN];
  assign mon_en = ctrl[`CTRL_MON_EN];
  assign multi = ctrl[`CTRL_MULTI_SCAN];
  assign thr_en = ctrl[`CTRL_THRESH_EN];

  // bus slave: one wait cycle, answer on the second
  logic ack;
  logic req;
  logic wr_go;
  assign req = avm_read | avm_write;
  assign avm_waitrequest = req & ~ack;
  assign wr_go = avm_write & ack;
  always_ff @(posedge clk) begin
    if (!resetn) ack <= 1'b0;
    else ack <= req & ~ack;
  end

  // write checks; a refused write leaves the register untouched
  logic [12:0] wr_on, wr_off;
  logic ctrl_bad, mon_bad, filt_bad, thr_bad, cfg_reject;
  assign wr_on = avm_writedata[28:16];
  assign wr_off = avm_writedata[12:0];
  // release and contactor monitoring are exclusive
  assign ctrl_bad = (avm_writedata[`CTRL_REL_EN] &
                     avm_writedata[`CTRL_MON_EN]) |
                    (avm_writedata[`CTRL_MODE_LSB +: 2] == 2'h3); // see (R05)
  assign mon_bad = avm_writedata[7:0] < `MON_STEPS_MIN; // see (R07)
  assign filt_bad = avm_writedata[6:0] > `FILTER_STEPS_MAX; // see (R14)
  assign thr_bad = wr_on < `THRESH_MIN_MS || wr_on > `THRESH_MAX_MS ||
                   wr_off < `THRESH_MIN_MS || wr_off > `THRESH_MAX_MS ||
                   wr_on < wr_off; // see (R16)
  always_comb begin
    cfg_reject = 1'b0;
    if (wr_go) begin
      if (avm_address == `OFS_CTRL) cfg_reject = ctrl_bad;
      else if (avm_address == `OFS_MON_TIME) cfg_reject = mon_bad;
      else if (avm_address == `OFS_FILTER) cfg_reject = filt_bad;
      else if (avm_address == `OFS_THRESH) cfg_reject = thr_bad;
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl <= `CTRL_RESET; // auto start, long range, double scan
      mon_steps <= `MON_STEPS_RESET; // see (R07)
      filter_steps <= `FILTER_RESET;
      on_ms <= `ON_MS_RESET; // see (R16)
      off_ms <= `OFF_MS_RESET;
      irq_mask <= 4'h0;
    end else if (wr_go && !cfg_reject) begin
      if (avm_address == `OFS_CTRL)
        ctrl <= avm_writedata[`CTRL_W-1:0];
      else if (avm_address == `OFS_MON_TIME)
        mon_steps <= avm_writedata[7:0];
      else if (avm_address == `OFS_FILTER)
        filter_steps <= avm_writedata[6:0];
      else if (avm_address == `OFS_THRESH) begin
        on_ms <= wr_on;
        off_ms <= wr_off;
      end else if (avm_address == `OFS_IRQ_MASK)
        irq_mask <= avm_writedata[3:0];
    end
  end

  // scan qualification: consecutive interrupted scans
  logic [1:0] consec; // saturating run of interrupted scans
  logic raw_blocked;
  always_ff @(posedge clk) begin
    if (!resetn) consec <= 2'h0;
    else if (scan_strobe) begin
      if (!scan_interrupted) consec <= 2'h0;
      else if (consec != 2'h3) consec <= consec + 2'h1;
    end
  end
  // two scans by default, three in multiple scan
  assign raw_blocked = consec >= (multi ? 2'h3 : 2'h2); // see (R12) (R13)

  // short interruption filter, counted in ms while blocked
  logic [7:0] blk_ms;
  logic qualified, qual_prev, qual_fall;
  always_ff @(posedge clk) begin
    if (!resetn) blk_ms <= 8'h0;
    else if (!raw_blocked) blk_ms <= 8'h0;
    else if (tick && blk_ms != 8'hFF) blk_ms <= blk_ms + 8'h1;
  end
  assign qualified = raw_blocked &&
                     blk_ms >= {filter_steps, 1'b0}; // see (R14)
  always_ff @(posedge clk) begin
    if (!resetn) qual_prev <= 1'b0;
    else qual_prev <= qualified;
  end
  assign qual_fall = qual_prev & ~qualified;

  // test input gate: with the on-high option the input must be high
  logic test_allow, allow;
  assign test_allow = !ctrl[`CTRL_TEST_EN] ||
                      (test_lvl == ctrl[`CTRL_TEST_ON_HIGH]); // see (R11)
  assign allow = test_allow && !qualified;

  // press timer; a press counts only if it lasted inside the window
  logic [12:0] press_ms;
  logic press_ok;
  always_ff @(posedge clk) begin
    if (!resetn) press_ms <= 13'h0;
    else if (!start_lvl) press_ms <= 13'h0;
    else if (tick && press_ms != 13'h1FFF) press_ms <= press_ms + 13'h1;
  end
  assign press_ok = start_fall && press_ms >= `PRESS_MIN_MS &&
                    press_ms <= `PRESS_MAX_MS; // see (R02) (R03)

  // threshold: clears counted within the off window
  logic [12:0] win_ms;
  logic win_open;
  logic [1:0] clears;
  logic hold_req;
  logic thr_live;
  assign thr_live = thr_en && mode == M_AUTO;
  logic hold_now; // third clear now, skip the one-cycle flash of on
  assign hold_now = thr_live && qual_fall && win_open && clears == 2'h2;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      win_open <= 1'b0;
      win_ms <= 13'h0;
      clears <= 2'h0;
      hold_req <= 1'b0;
    end else begin
      if (state == S_HOLD || !thr_live) hold_req <= 1'b0;
      if (!thr_live) begin
        win_open <= 1'b0;
        clears <= 2'h0;
      end else if (qual_fall) begin
        if (!win_open) begin
          win_open <= 1'b1;
          win_ms <= 13'h0;
          clears <= 2'h1;
        end else if (clears == 2'h2) begin
          hold_req <= 1'b1; // third clear inside the window, see (R15)
          win_open <= 1'b0;
          clears <= 2'h0;
        end else clears <= clears + 2'h1;
      end else if (win_open && tick) begin
        if (win_ms >= off_ms) begin
          win_open <= 1'b0;
          clears <= 2'h0;
        end else win_ms <= win_ms + 13'h1;
      end
    end
  end

  // hold timer for the threshold on time
  logic [12:0] hold_ms;
  always_ff @(posedge clk) begin
    if (!resetn) hold_ms <= 13'h0;
    else if (state != S_HOLD) hold_ms <= 13'h0;
    else if (tick) hold_ms <= hold_ms + 13'h1;
  end

  // contactor monitor: feedback must toggle after every output change
  logic [10:0] mon_ms, fb_ms;
  logic fb_pending, mon_fail, out_on, out_prev;
  assign mon_ms = 11'(mon_steps) * `MON_STEP_MS;
  assign out_on = state == S_ON;
  always_ff @(posedge clk) begin
    if (!resetn) out_prev <= 1'b0;
    else out_prev <= out_on;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fb_pending <= 1'b0;
      fb_ms <= 11'h0;
    end else if (!mon_en || state == S_LOCK) fb_pending <= 1'b0;
    else if (out_on != out_prev) begin
      fb_pending <= 1'b1;
      fb_ms <= 11'h0;
    end else if (fb_rise || fb_fall) fb_pending <= 1'b0;
    else if (fb_pending && tick && fb_ms != 11'h7FF)
      fb_ms <= fb_ms + 11'h1;
  end
  assign mon_fail = fb_pending && fb_ms >= mon_ms; // see (R06)

  // output state machine
  always_comb begin
    next_state = state;
    case (state)
      S_OFF: begin
        if (hold_req || hold_now) next_state = S_HOLD; // see (R15)
        else if (allow && mode == M_AUTO && !rel_en)
          next_state = S_ON; // see (R01)
        else if (allow) next_state = S_ARMED;
      end
      S_ARMED: begin
        if (hold_req) next_state = S_HOLD;
        else if (!allow) next_state = S_OFF;
        else if (rel_en && rel_rise) next_state = S_ON; // see (R04)
        else if (!rel_en && mode != M_AUTO && press_ok)
          next_state = S_ON; // see (R02) (R03)
        else if (!rel_en && mode == M_AUTO) next_state = S_ON;
      end
      S_ON: begin
        if (!allow) next_state = S_OFF; // see (R18)
        else if (hold_req) next_state = S_HOLD;
        else if (!rel_en && mode == M_MANUAL_OFF && press_ok)
          next_state = S_OFF; // see (R03)
      end
      S_HOLD: begin
        if (tick && hold_ms >= on_ms) next_state = S_OFF; // see (R15)
      end
      S_LOCK: next_state = S_LOCK; // only reset leaves, see (R06)
      default: next_state = S_OFF;
    endcase
    if (mon_fail) next_state = S_LOCK;
  end
  always_ff @(posedge clk) begin
    if (!resetn) state <= S_OFF;
    else state <= next_state;
  end

  // pins driven from state and settings
  always_ff @(posedge clk) begin
    if (!resetn) begin
      protective_switch_output <= 2'h0;
      scan_pattern <= 2'h0;
      short_range <= 1'b0;
      waiting_for_start <= 1'b0;
      lockout <= 1'b0;
    end else begin
      // both channels follow one decision
      protective_switch_output <= {2{next_state == S_ON}};
      // interference rejection only on top of coding
      scan_pattern <= {ctrl[`CTRL_CODING] & ctrl[`CTRL_REJECT],
                       ctrl[`CTRL_CODING]}; // see (R09) (R10)
      short_range <= ctrl[`CTRL_SHORT_RANGE]; // see (R08)
      waiting_for_start <= next_state == S_ARMED;
      lockout <= next_state == S_LOCK;
    end
  end

  // events: drop, lockout, refused setting, start accepted
  logic [3:0] events;
  logic [3:0] w1c;
  assign events = {state == S_ARMED && next_state == S_ON, cfg_reject,
                   state != S_LOCK && next_state == S_LOCK,
                   state == S_ON && next_state != S_ON};
  assign w1c = (wr_go && avm_address == `OFS_IRQ_STATUS) ?
               avm_writedata[3:0] : 4'h0;
  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) irq_status <= 4'h0;
    else irq_status <= (irq_status & ~w1c) | events;
  end
  assign irq = |(irq_status & irq_mask);

  // reported response time grows with coding, rejection on top of coding, and scans
  logic [15:0] resp_base, resp_ms;
  always_comb begin
    resp_base = 16'(BASE_RESP_MS);
    if (ctrl[`CTRL_CODING]) begin
      resp_base = resp_base + 16'(CODING_ADD_MS); // see (R09)
      if (ctrl[`CTRL_REJECT])
        resp_base = resp_base + 16'(REJECT_ADD_MS); // see (R10)
    end
    resp_ms = resp_base;
    if (multi) resp_ms = resp_base + resp_base / 16'd3; // see (R13)
    resp_ms = resp_ms + {8'h0, filter_steps, 1'b0};
  end

  // read data, set as the wait cycle closes
  always_ff @(posedge clk) begin
    if (!resetn) avm_readdata <= 32'h0;
    else if (avm_read && !ack) begin
      if (avm_address == `OFS_CTRL)
        avm_readdata <= {19'h0, ctrl};
      else if (avm_address == `OFS_MON_TIME)
        avm_readdata <= {24'h0, mon_steps};
      else if (avm_address == `OFS_FILTER)
        avm_readdata <= {25'h0, filter_steps};
      else if (avm_address == `OFS_THRESH)
        avm_readdata <= {3'h0, on_ms, 3'h0, off_ms};
      else if (avm_address == `OFS_STATUS)
        avm_readdata <= {25'h0, state, ~raw_blocked, qualified,
                         fb_pending, out_on};
      else if (avm_address == `OFS_IRQ_STATUS)
        avm_readdata <= {28'h0, irq_status};
      else if (avm_address == `OFS_IRQ_MASK)
        avm_readdata <= {28'h0, irq_mask};
      else if (avm_address == `OFS_RESP_TIME)
        avm_readdata <= {16'h0, resp_ms};
      else avm_readdata <= 32'h0; // unmapped reads zero
    end
  end
endmodule
`default_nettype wire

// [bench/protective_output_start_control_props.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the safety outputs against the pins and the scan results
module psc_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic avm_write,
  input wire logic scan_strobe,
  input wire logic scan_interrupted,
  input wire logic start_button,
  input wire logic start_release,
  input wire logic [1:0] protective_switch_output,
  input wire logic [1:0] scan_pattern,
  input wire logic short_range,
  input wire logic waiting_for_start,
  input wire logic lockout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [1:0] blk_cnt; // run of interrupted scans, saturates at three
  // a clear scan ends the run, so three means the field is surely blocked
  always_ff @(posedge clk) begin
    if (!resetn) begin
      blk_cnt <= 2'h0;
    end else if (scan_strobe && !scan_interrupted) begin
      blk_cnt <= 2'h0;
    end else if (scan_strobe && blk_cnt != 2'h3) begin
      blk_cnt <= blk_cnt + 2'h1;
    end
  end
  property p_lock_off;
    lockout |-> protective_switch_output == 2'h0;
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("on in lockout");
  property p_lock_sticky;
    lockout |=> lockout;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock left");
  property p_wait_off;
    waiting_for_start |-> protective_switch_output == 2'h0;
  endproperty
  a_wait_off: assert property (p_wait_off)
    else $error("on while armed");
  property p_reject_coding;
    scan_pattern[1] |-> scan_pattern[0];
  endproperty
  a_reject_coding: assert property (p_reject_coding)
    else $error("bad pattern");
  property p_pair;
    protective_switch_output[0] == protective_switch_output[1];
  endproperty
  a_pair: assert property (p_pair)
    else $error("outputs differ");
  property p_no_rise_blocked;
    $rose(protective_switch_output[0]) |-> blk_cnt != 2'h3;
  endproperty
  a_no_rise_blocked: assert property (p_no_rise_blocked)
    else $error("on blocked");
  property p_start_edge;
    $rose(protective_switch_output[0]) && $past(waiting_for_start)
      |-> !start_button || start_release;
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("on, no start");
  property p_cfg_change;
    $changed({short_range, scan_pattern}) |->
      $past(avm_write) || $past(avm_write, 2);
  endproperty
  a_cfg_change: assert property (p_cfg_change)
    else $error("cfg moved");
endmodule
`default_nettype wire

// [bench/contactor_model.sv]
`timescale 1ns/1ps
`default_nettype none
// contactor whose auxiliary contact follows the coil a few cycles late
module contactor_model #(
  parameter int DELAY = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic coil,
  input wire logic stuck,
  output logic feedback
);
  logic [DELAY-1:0] travel; // armature travel time
  // a welded contact (stuck) freezes the feedback, which must end in lockout
  always_ff @(posedge clk) begin
    if (!resetn) begin
      travel <= '0;
      feedback <= 1'b0;
    end else begin
      travel <= {travel[DELAY-2:0], coil};
      if (!stuck) begin
        feedback <= travel[DELAY-1];
      end
    end
  end
endmodule
`default_nettype wire

// [bench/protective_output_start_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "curtain_regs.svh"
module protective_output_start_control_tb;
  logic clk = 1'b0;
  logic resetn, avm_read, avm_write, avm_waitrequest, irq, stuck;
  logic scan_strobe, scan_interrupted, start_button, start_release, test_pin;
  logic contactor_feedback, short_range, waiting_for_start, lockout;
  logic [4:0] avm_address;
  logic [31:0] avm_writedata, avm_readdata, rd;
  logic [1:0] protective_switch_output, scan_pattern;
  int num_errors = 0;
  int n_tests = 0;
  // ctrl, filter steps, response ms, pattern, range
  logic [12:0] t_ctrl [6] = '{13'h0, 13'h20, 13'h60, 13'h40, 13'h220, 13'h70};
  logic [6:0] t_filt [6] = '{7'd5, 7'd0, 7'd0, 7'd0, 7'd0, 7'd0};
  logic [31:0] t_resp [6] = '{32'd20, 32'd14, 32'd20, 32'd10, 32'd18, 32'd20};
  logic [2:0] t_out [6] = '{3'h0, 3'h1, 3'h3, 3'h0, 3'h1, 3'h7};
  // refused writes and the value that must remain
  logic [4:0] r_adr [6] = '{5'h00, 5'h00, 5'h04, 5'h08, 5'h0C, 5'h0C};
  logic [31:0] r_dat [6] = '{32'hC, 32'h3, 32'h9, 32'd88, 32'h00C8012C,
    32'h001E001D};
  logic [31:0] r_exp [6] = '{32'h0, 32'h0, 32'h3C, 32'h0, 32'h01F400FA,
    32'h01F400FA};
  always #2.5 clk = ~clk;
  // tick shortened to 20 cycles so 1 ms costs 20 clocks
  protective_output_start_control #(.TICK_CYCLES(20)) DUT (
    .clk(clk), .resetn(resetn), .avm_address(avm_address),
    .avm_read(avm_read), .avm_write(avm_write),
    .avm_writedata(avm_writedata), .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest), .scan_strobe(scan_strobe),
    .scan_interrupted(scan_interrupted), .start_button(start_button),
    .start_release(start_release), .contactor_feedback(contactor_feedback),
    .test_pin(test_pin), .protective_switch_output(protective_switch_output),
    .scan_pattern(scan_pattern), .short_range(short_range),
    .waiting_for_start(waiting_for_start), .lockout(lockout), .irq(irq));
  contactor_model u_contactor (.clk(clk), .resetn(resetn),
    .coil(protective_switch_output[0]), .stuck(stuck),
    .feedback(contactor_feedback));
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    @(posedge clk);
    avm_address <= a;
    avm_write <= wr;
    avm_read <= !wr;
    avm_writedata <= d;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avm_waitrequest === 1'b0) break;
      if (i == 49) begin
        num_errors++;
        wrap_up();
      end
    end
    rd = avm_readdata;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [4:0] a,
                       input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    check(what, rd & m, e);
  endtask
  // n scans, all blocked or all clear
  task automatic scans(input int n, input logic blk);
    repeat (n) begin
      @(posedge clk);
      scan_strobe <= 1'b1;
      scan_interrupted <= blk;
      @(posedge clk);
      scan_strobe <= 1'b0;
    end
  endtask
  task automatic wait_out(input logic [1:0] e, input int lim);
    for (int i = 0; i < lim && protective_switch_output !== e; i++) begin
      @(posedge clk);
    end
    check("outputs", {30'h0, protective_switch_output}, {30'h0, e});
  endtask
  task automatic wait_bit(input string what, ref logic s, input logic e,
                          input int lim);
    for (int i = 0; i < lim && s !== e; i++) begin
      @(posedge clk);
    end
    check(what, {31'h0, s}, {31'h0, e});
  endtask
  task automatic press(input int ms);
    start_button <= 1'b1;
    repeat (ms * 20) @(posedge clk);
    start_button <= 1'b0;
  endtask
  initial begin
    {resetn, avm_read, avm_write, scan_strobe, scan_interrupted} = 5'h0;
    {start_button, start_release, test_pin, stuck} = 4'h0;
    avm_address = 5'h00;
    avm_writedata = 32'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    wait_out(2'h3, 50);
    rdchk("ctrl", `OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rdchk("mon", `OFS_MON_TIME, 32'h3C, 32'hFFFFFFFF);
    rdchk("thresh", `OFS_THRESH, 32'h01F400FA, 32'hFFFFFFFF);
    rdchk("unmapped", 5'h02, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, `OFS_RESP_TIME, 32'hFFFF);
    rdchk("resp_ro", `OFS_RESP_TIME, 32'd10, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `OFS_CTRL, {19'h0, t_ctrl[i]});
      bus(1'b1, `OFS_FILTER, {25'h0, t_filt[i]});
      rdchk("resp", `OFS_RESP_TIME, t_resp[i], 32'hFFFFFFFF);
      repeat (2) @(posedge clk);
      check("cfg_pins",
        {29'h0, short_range, scan_pattern}, {29'h0, t_out[i]});
    end
    bus(1'b1, `OFS_FILTER, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h1800);
    rdchk("ctrl_mb", `OFS_CTRL, 32'h1800, 32'hFFFFFFFF);
    bus(1'b1, `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_IRQ_STATUS, 32'hF);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, r_adr[i], r_dat[i]);
      rdchk("refused", r_adr[i], r_exp[i],
        32'hFFFFFFFF);
    end
    rdchk("irq_cfg", `OFS_IRQ_STATUS, 32'h4, 32'h4);
    bus(1'b1, `OFS_IRQ_MASK, 32'h4);
    wait_bit("irq_on", irq, 1'b1, 5);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h4);
    wait_bit("irq_off", irq, 1'b0, 5);
    scans(1, 1'b1);
    scans(1, 1'b0);
    wait_out(2'h3, 1);
    scans(2, 1'b1);
    wait_out(2'h0, 20);
    scans(2, 1'b0);
    wait_out(2'h3, 20);
    bus(1'b1, `OFS_CTRL, 32'h200);
    scans(2, 1'b1);
    repeat (10) @(posedge clk);
    wait_out(2'h3, 1);
    scans(1, 1'b1);
    wait_out(2'h0, 20);
    scans(2, 1'b0);
    wait_out(2'h3, 20);
    bus(1'b1, `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_FILTER, 32'h2);
    scans(2, 1'b1);
    repeat (40) @(posedge clk);
    wait_out(2'h3, 1);
    wait_out(2'h0, 200);
    scans(2, 1'b0);
    wait_out(2'h3, 20);
    bus(1'b1, `OFS_FILTER, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h80);
    test_pin <= 1'b1;
    wait_out(2'h0, 20);
    bus(1'b1, `OFS_CTRL, 32'h180);
    wait_out(2'h3, 20);
    test_pin <= 1'b0;
    wait_out(2'h0, 20);
    bus(1'b1, `OFS_CTRL, 32'h1);
    wait_bit("armed", waiting_for_start, 1'b1, 50);
    press(20);
    repeat (40) @(posedge clk);
    wait_out(2'h0, 1);
    press(60);
    wait_out(2'h3, 40);
    bus(1'b1, `OFS_CTRL, 32'h2);
    press(60);
    wait_out(2'h0, 40);
    wait_bit("armed", waiting_for_start, 1'b1, 50);
    press(60);
    wait_out(2'h3, 40);
    bus(1'b1, `OFS_CTRL, 32'h4);
    scans(2, 1'b1);
    wait_out(2'h0, 20);
    scans(2, 1'b0);
    wait_bit("armed", waiting_for_start, 1'b1, 50);
    start_release <= 1'b1;
    wait_out(2'h3, 40);
    start_release <= 1'b0;
    bus(1'b1, `OFS_THRESH, 32'h0028001E);
    bus(1'b1, `OFS_CTRL, 32'h400);
    for (int i = 0; i < 6; i++) scans(2, !i[0]);
    repeat (600) @(posedge clk);
    wait_out(2'h0, 1);
    wait_out(2'h3, 400);
    bus(1'b1, `OFS_CTRL, 32'h8);
    bus(1'b1, `OFS_MON_TIME, 32'hA);
    scans(2, 1'b1);
    wait_out(2'h0, 20);
    scans(2, 1'b0);
    wait_out(2'h3, 20);
    repeat (1100) @(posedge clk);
    wait_bit("no_lock", lockout, 1'b0, 1);
    stuck <= 1'b1;
    scans(2, 1'b1);
    wait_out(2'h0, 20);
    wait_bit("lock", lockout, 1'b1, 1200);
    scans(2, 1'b0);
    repeat (200) @(posedge clk);
    wait_out(2'h0, 1);
    rdchk("status", `OFS_STATUS, 32'h68, 32'hFFFFFFFF);
    rdchk("irq_lock", `OFS_IRQ_STATUS, 32'h2, 32'h2);
    wrap_up();
  end
endmodule
bind protective_output_start_control psc_checker u_checker (
  .clk(clk), .resetn(resetn), .avm_write(avm_write),
  .scan_strobe(scan_strobe), .scan_interrupted(scan_interrupted),
  .start_button(start_button), .start_release(start_release),
  .protective_switch_output(protective_switch_output),
  .scan_pattern(scan_pattern), .short_range(short_range),
  .waiting_for_start(waiting_for_start), .lockout(lockout));
`default_nettype wire
